// ==== src/cesr_regs.v ====
// Channel event and status register slice behind an AXI4-Lite slave port.
// Assumes event strobes and status levels are synchronous to aclk.
//
// Function
// - Enable bit 1 gates an interrupt on far-end receiver detect, reported in status bit 1.
// - Enable bits 2 and 3 gate level-below and level-at-or-above low threshold events.
// - Enable bits 4 and 5 gate level-below and level-at-or-above high threshold events.
// - Enable bits 6 and 7 gate lock loss and lock recovery events, status bits 6 and 7.
// - An 8-bit pattern error count saturates at all ones and clears when read.
// - An 8-bit parity indicator marks each errored bit position of the parity byte.
// - Status bit 2 shows the negotiation request for the processor to resolve priority.
// - Status bit 3 is one when negotiation is complete and zero while it runs.
// - Status bit 4 is one when a page was received from the link partner.
// - Status bit 5 is one when the next page to transmit is loaded.
// - Status bit 6 latches on buffer underrun and clears when the register is read.
// - Status bit 7 latches on buffer overrun and clears when the register is read.
`timescale 1ns/100ps
`include "cesr_map.vh"

module cesr_regs #(
  parameter ADDR_W = 12,
  parameter COUNT_W = 8
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Receiver event strobes
  input wire ev_far_end_detect,
  input wire ev_level_below_lo,
  input wire ev_level_at_lo,
  input wire ev_level_below_hi,
  input wire ev_level_at_hi,
  input wire ev_lock_loss,
  input wire ev_lock_regain,
  // Pattern checker and parity checker
  input wire pattern_error,
  input wire [7:0] parity_error_lanes,
  // Link negotiation levels
  input wire link_negotiation_priority_req,
  input wire link_negotiation_complete,
  input wire link_negotiation_page_rx,
  input wire link_negotiation_next_loaded,
  // Rate compensation buffer strobes
  input wire rate_compensation_underrun,
  input wire rate_compensation_overrun,
  // Channel interrupt
  output reg channel_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg aw_held;
  reg w_held;
  reg [7:0] aw_idx;
  reg aw_hit;
  reg [7:0] w_byte;
  reg w_lane0;
  reg [7:0] irq_enable;
  reg [7:0] parity_bits;
  reg [3:0] neg_levels;
  reg [7:0] next_rdata;
  reg next_rhit;

  wire wr_fire;
  wire rd_fire;
  wire [7:0] rd_idx;
  wire [7:0] wr_idx_in;
  wire [6:0] ev_set;
  wire [6:0] ev_clr;
  wire [6:0] ev_flags;
  wire [7:0] event_status;
  wire [1:0] buf_set;
  wire [1:0] buf_clr;
  wire [1:0] buf_flags;
  wire [7:0] neg_buf_status;
  wire [COUNT_W-1:0] pattern_count;
  wire count_clr;
  wire status_read;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Byte address bits 1:0 are ignored; the word index selects the register
  assign wr_idx_in = s_axi_awaddr[9:2];
  assign rd_idx = s_axi_araddr[9:2];

  function is_mapped;
    input [ADDR_W-1:0] addr;
    reg [7:0] idx;
    begin
      idx = addr[9:2];
      // Upper address bits must be zero or the access is refused
      is_mapped = (addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) &&
                  ((idx == `CESR_IDX_IRQ_ENABLE) ||
                   (idx == `CESR_IDX_EVENT_STATUS) ||
                   (idx >= `CESR_IDX_RSVD_A && idx <= `CESR_IDX_NEG_BUF_STATUS));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order

  // Write takes effect the cycle after both halves are held
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h00;
      aw_hit <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CESR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= wr_idx_in;
        aw_hit <= is_mapped(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        // Only byte lane 0 carries a register; upper lanes are dropped
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_hit ? `CESR_RESP_OKAY : `CESR_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        // Ready returns only after the response is taken: one write at a time
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable register

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= `CESR_RST_ENABLE;
    end else if (wr_fire && w_lane0 && aw_idx == `CESR_IDX_IRQ_ENABLE) begin
      // Bit 0 has no event behind it and stays zero
      irq_enable <= {w_byte[7:1], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status: sticky, write one to clear

  // Flag n-1 of the row is status bit n; bit 0 has no event behind it
  assign ev_set[`CESR_EV_FAR_END - 1] = ev_far_end_detect;
  assign ev_set[`CESR_EV_BELOW_LO - 1] = ev_level_below_lo;
  assign ev_set[`CESR_EV_AT_LO - 1] = ev_level_at_lo;
  assign ev_set[`CESR_EV_BELOW_HI - 1] = ev_level_below_hi;
  assign ev_set[`CESR_EV_AT_HI - 1] = ev_level_at_hi;
  assign ev_set[`CESR_EV_LOCK_LOSS - 1] = ev_lock_loss;
  assign ev_set[`CESR_EV_LOCK_REGAIN - 1] = ev_lock_regain;

  assign ev_clr = (wr_fire && w_lane0 && aw_idx == `CESR_IDX_EVENT_STATUS) ?
                  w_byte[`CESR_EV_MSB:`CESR_EV_LSB] : 7'h00;

  cesr_sticky #(
    .WIDTH(7)
  ) u_event_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(ev_set),
    .clr(ev_clr),
    .flags(ev_flags)
  );

  assign event_status = {ev_flags, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Channel interrupt

  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_irq <= 1'b0;
    end else begin
      // Registered, so it trails a flag change by one cycle
      channel_irq <= |(event_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side effects

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  // Only a mapped read clears, so a refused read has no side effect
  assign count_clr = rd_fire && is_mapped(s_axi_araddr) &&
                     rd_idx == `CESR_IDX_PATTERN_COUNT;
  assign status_read = rd_fire && is_mapped(s_axi_araddr) &&
                       rd_idx == `CESR_IDX_NEG_BUF_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern error counter

  cesr_sat_count #(
    .WIDTH(COUNT_W)
  ) u_pattern_count (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(pattern_error),
    .clr(count_clr),
    .count(pattern_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Parity indicator and negotiation levels

  always @(posedge aclk) begin
    if (!aresetn) begin
      parity_bits <= 8'h00;
      neg_levels <= 4'h0;
    end else begin
      // Follows the checker each cycle; it holds no history of its own
      parity_bits <= parity_error_lanes;
      neg_levels <= {link_negotiation_next_loaded,
                     link_negotiation_page_rx,
                     link_negotiation_complete,
                     link_negotiation_priority_req};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer underrun and overrun: sticky, clear on read

  assign buf_set = {rate_compensation_overrun, rate_compensation_underrun};
  // Both buffer flags share the one read that clears them
  assign buf_clr = {status_read, status_read};

  cesr_sticky #(
    .WIDTH(2)
  ) u_buffer_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(buf_set),
    .clr(buf_clr),
    .flags(buf_flags)
  );

  // Bits 1:0 are reserved and read as zero
  assign neg_buf_status[1:0] = 2'b00;
  assign neg_buf_status[`CESR_NB_PRIORITY_REQ] = neg_levels[0];
  assign neg_buf_status[`CESR_NB_COMPLETE] = neg_levels[1];
  assign neg_buf_status[`CESR_NB_PAGE_RX] = neg_levels[2];
  assign neg_buf_status[`CESR_NB_NEXT_LOADED] = neg_levels[3];
  assign neg_buf_status[`CESR_NB_UNDERRUN] = buf_flags[0];
  assign neg_buf_status[`CESR_NB_OVERRUN] = buf_flags[1];

  ////////////////////////////////////////////////////////////////////////////
  // Read data multiplexer

  always @* begin
    next_rdata = 8'h00;
    next_rhit = is_mapped(s_axi_araddr);
    case (rd_idx)
      `CESR_IDX_IRQ_ENABLE: begin
        next_rdata = irq_enable;
      end
      `CESR_IDX_PATTERN_COUNT: begin
        next_rdata = pattern_count;
      end
      `CESR_IDX_PARITY_BITS: begin
        next_rdata = parity_bits;
      end
      `CESR_IDX_NEG_BUF_STATUS: begin
        next_rdata = neg_buf_status;
      end
      `CESR_IDX_EVENT_STATUS: begin
        next_rdata = event_status;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
    // Refused reads return zero so no internal state leaks out
    if (!next_rhit) begin
      next_rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CESR_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        // Data captured before the clear lands, so the read returns the old value
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, next_rdata};
        s_axi_rresp <= next_rhit ? `CESR_RESP_OKAY : `CESR_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // cesr_regs

// ==== src/cesr_map.vh ====
// Address indices, field positions and reset values of the channel event
// and status register slice. Byte address on the bus is four times the index.
`ifndef CESR_MAP_VH
`define CESR_MAP_VH

// Register indices
`define CESR_IDX_IRQ_ENABLE 8'h17
`define CESR_IDX_RSVD_A 8'h80
`define CESR_IDX_PATTERN_COUNT 8'h81
`define CESR_IDX_RSVD_B 8'h82
`define CESR_IDX_PARITY_BITS 8'h83
`define CESR_IDX_RSVD_C 8'h84
`define CESR_IDX_NEG_BUF_STATUS 8'h85
`define CESR_IDX_EVENT_STATUS 8'h97

// Event enable and event status layout (bit 0 reserved)
`define CESR_EV_FAR_END 1
`define CESR_EV_BELOW_LO 2
`define CESR_EV_AT_LO 3
`define CESR_EV_BELOW_HI 4
`define CESR_EV_AT_HI 5
`define CESR_EV_LOCK_LOSS 6
`define CESR_EV_LOCK_REGAIN 7
`define CESR_EV_LSB 1
`define CESR_EV_MSB 7

// Negotiation and buffer status layout (bits 0..1 reserved)
`define CESR_NB_PRIORITY_REQ 2
`define CESR_NB_COMPLETE 3
`define CESR_NB_PAGE_RX 4
`define CESR_NB_NEXT_LOADED 5
`define CESR_NB_UNDERRUN 6
`define CESR_NB_OVERRUN 7

// Reset values
`define CESR_RST_ENABLE 8'h00
`define CESR_RST_COUNT 8'h00
`define CESR_RST_STATUS 8'h00

// Bus responses
`define CESR_RESP_OKAY 2'b00
`define CESR_RESP_DECERR 2'b11

`endif

// ==== src/cesr_sticky.v ====
// Row of sticky flags: each bit latches on its set strobe and drops on its
// clear strobe. Assumes set and clear are one-cycle pulses in the aclk domain.
`timescale 1ns/100ps
module cesr_sticky #(
  parameter WIDTH = 7
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clr,
  output wire [WIDTH-1:0] flags
);

  reg [WIDTH-1:0] flag_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          flag_q[i] <= 1'b0;
        end else begin
          // A set in the clearing cycle is kept, so no event is lost
          flag_q[i] <= set[i] | (flag_q[i] & ~clr[i]);
        end
      end
    end
  endgenerate

  assign flags = flag_q;

endmodule // cesr_sticky

// ==== src/cesr_sat_count.v ====
// Saturating event counter with a clear strobe.
// Assumes inc and clr are one-cycle pulses in the aclk domain.
`timescale 1ns/100ps
module cesr_sat_count #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire inc,
  input wire clr,
  output reg [WIDTH-1:0] count
);

  wire at_top;

  assign at_top = &count;

  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= {WIDTH{1'b0}};
    end else if (clr) begin
      // An error arriving with the clearing read counts as the first of the next run
      count <= {{(WIDTH-1){1'b0}}, inc};
    end else if (inc && !at_top) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // cesr_sat_count

// ==== tb/cesr_regs_checker.sv ====
// Checker for the channel event register slice.
// Assumes it is bound to cesr_regs and sees only that module's ports.
`timescale 1ns/100ps
module cesr_regs_checker (
  input logic aclk, aresetn, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input logic channel_irq, link_negotiation_complete, s_axi_bready,
  input logic [11:0] s_axi_araddr,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic [7:0] parity_error_lanes
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence ar_hit(a);
    ar_take ##0 s_axi_araddr == a;
  endsequence
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  rd_lat_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  wr_resp_a: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response not held");
  dec_err_a: assert property (ar_hit(12'h004) |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  neg_level_a: assert property (
    ar_hit(12'h214) ##0 $stable(link_negotiation_complete)
    |=> s_axi_rdata[3] == $past(link_negotiation_complete)) else $error("completion bit wrong");
  parity_read_a: assert property (
    ar_hit(12'h20c) ##0 $stable(parity_error_lanes)
    |=> s_axi_rdata[7:0] == $past(parity_error_lanes)) else $error("parity bits wrong");
  irq_fall_a: assert property (
    $fell(channel_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt dropped without a write");
endmodule // cesr_regs_checker

// ==== tb/test_cesr_regs.sv ====
// Self-checking bench for the channel event register slice.
// Assumes one 25 MHz clock; the bench drives every input of cesr_regs.
`timescale 1ns/100ps
module test_cesr_regs;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, channel_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] parity_error_lanes = 8'h0;
  logic [9:0] pv = 10'h0;
  logic [3:0] neg = 4'h0;
  int n_fail = 0, n_tests = 0;
  always #20 aclk = ~aclk;
  cesr_regs i_cesr_regs (.*, .ev_far_end_detect(pv[0]), .ev_level_below_lo(pv[1]),
    .ev_level_at_lo(pv[2]), .ev_level_below_hi(pv[3]), .ev_level_at_hi(pv[4]),
    .ev_lock_loss(pv[5]), .ev_lock_regain(pv[6]), .pattern_error(pv[7]),
    .rate_compensation_underrun(pv[8]), .rate_compensation_overrun(pv[9]),
    .link_negotiation_priority_req(neg[0]), .link_negotiation_complete(neg[1]),
    .link_negotiation_page_rx(neg[2]), .link_negotiation_next_loaded(neg[3]));
  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One write or one read; waits an edge first so no signal is driven twice in a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    bit done;
    done = 0;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    for (i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid || s_axi_rvalid) begin
        done = 1;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        rsp = w ? s_axi_bresp : s_axi_rresp;
        rdat = s_axi_rdata;
      end
    end
    if (!done) begin
      n_fail++;
      end_sim;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    xfer(1'h0, a, 8'h0);
    chk(rdat, e);
    chk({30'h0, rsp}, {30'h0, r});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // Waits at most 40 edges until the chosen answer is sampled high
  task automatic wait_hi(input int s);
    int i;
    bit hit;
    hit = 0;
    for (i = 0; i < 40 && !hit; i++) begin
      @(posedge aclk);
      case (s)
        0: hit = s_axi_awready;
        1: hit = s_axi_wready;
        2: hit = s_axi_bvalid;
        3: hit = s_axi_rvalid;
        default: hit = s_axi_arready;
      endcase
    end
    if (!hit) begin
      n_fail++;
      end_sim;
    end
  endtask
  task automatic pulse(input logic [9:0] v);
    pv <= v;
    @(posedge aclk);
    pv <= 10'h0;
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_map;
    int i;
    logic [11:0] m [8] = '{12'h05c, 12'h200, 12'h204, 12'h208, 12'h20c, 12'h210, 12'h214,
      12'h25c};
    for (i = 0; i < 8; i++) rd(m[i], 32'h0, 2'h0);
    rd(12'h004, 32'h0, 2'h3);
    xfer(1'h1, 12'h004, 8'hff);
    chk({30'h0, rsp}, 32'h3);
    xfer(1'h1, 12'h200, 8'hff);
    rd(12'h200, 32'h0, 2'h0);
    xfer(1'h1, 12'h05c, 8'hff);
    rd(12'h05c, 32'hfe, 2'h0);
    $display("map test done");
  endtask
  task automatic t_events;
    int k;
    for (k = 1; k < 8; k++) begin
      xfer(1'h1, 12'h05c, 8'h0);
      pulse(10'h1 << (k - 1));
      tick(1);
      chk(channel_irq, 32'h0);
      rd(12'h25c, 32'h1 << k, 2'h0);
      xfer(1'h1, 12'h05c, 8'h1 << k);
      tick(2);
      chk(channel_irq, 32'h1);
      xfer(1'h1, 12'h25c, 8'h1 << k);
      tick(2);
      chk(channel_irq, 32'h0);
      rd(12'h25c, 32'h0, 2'h0);
    end
    $display("event test done");
  endtask
  task automatic t_count;
    int i;
    for (i = 0; i < 3; i++) pulse(10'h80);
    rd(12'h204, 32'h3, 2'h0);
    rd(12'h204, 32'h0, 2'h0);
    // 300 errors would wrap to 0x2c without saturation
    for (i = 0; i < 300; i++) pulse(10'h80);
    rd(12'h204, 32'hff, 2'h0);
    rd(12'h204, 32'h0, 2'h0);
    $display("count test done");
  endtask
  task automatic t_status;
    parity_error_lanes <= 8'ha5;
    neg <= 4'h5;
    rd(12'h20c, 32'ha5, 2'h0);
    rd(12'h214, 32'h14, 2'h0);
    parity_error_lanes <= 8'h5a;
    neg <= 4'ha;
    rd(12'h20c, 32'h5a, 2'h0);
    rd(12'h214, 32'h28, 2'h0);
    pulse(10'h100);
    rd(12'h214, 32'h68, 2'h0);
    rd(12'h214, 32'h28, 2'h0);
    pulse(10'h200);
    rd(12'h214, 32'ha8, 2'h0);
    rd(12'h214, 32'h28, 2'h0);
    $display("status test done");
  endtask
  // Masked lane, address before data, late response and late read ready
  task automatic t_handshake;
    s_axi_wstrb <= 4'he;
    xfer(1'h1, 12'h05c, 8'h24);
    chk({30'h0, rsp}, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h05c, 32'h80, 2'h0);
    s_axi_awaddr <= 12'h05c;
    s_axi_awvalid <= 1'h1;
    wait_hi(0);
    s_axi_awvalid <= 1'h0;
    repeat (2) @(posedge aclk);
    s_axi_wdata <= 32'h0000_0042;
    s_axi_wvalid <= 1'h1;
    wait_hi(1);
    s_axi_wvalid <= 1'h0;
    repeat (3) @(posedge aclk);
    chk(s_axi_bvalid, 32'h1);
    s_axi_bready <= 1'h1;
    wait_hi(2);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, 32'h0);
    rd(12'h05c, 32'h42, 2'h0);
    pulse(10'h80);
    pulse(10'h80);
    s_axi_araddr <= 12'h204;
    s_axi_arvalid <= 1'h1;
    wait_hi(4);
    s_axi_arvalid <= 1'h0;
    pulse(10'h80);
    chk(s_axi_rvalid, 32'h1);
    chk(s_axi_rdata, 32'h2);
    s_axi_rready <= 1'h1;
    wait_hi(3);
    s_axi_rready <= 1'h0;
    rd(12'h204, 32'h1, 2'h0);
    $display("handshake test done");
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_map;
    t_events;
    t_count;
    t_status;
    t_handshake;
    end_sim;
  end
endmodule // test_cesr_regs
bind cesr_regs cesr_regs_checker i_cesr_regs_checker (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .channel_irq(channel_irq),
  .link_negotiation_complete(link_negotiation_complete),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .parity_error_lanes(parity_error_lanes)
);
